/* smx_params.svh */
// constants for the set-max command and security block
`ifndef SMX_PARAMS_SVH
`define SMX_PARAMS_SVH
`define SMX_OPCODE 8'hF9
`define SMX_FEAT_SETPW 8'h01
`define SMX_FEAT_LOCK 8'h02
`define SMX_FEAT_UNLOCK 8'h03
`define SMX_FEAT_FREEZE 8'h04
`define SMX_ERR_NONE 8'h00
`define SMX_ERR_ABT 8'h04
`define SMX_STS_RDY 8'h40
`define SMX_STS_DRQ 8'h08
`define SMX_STS_ERR 8'h01
`define SMX_CHS_MAX_SECT 8'h3F
`define SMX_TRIES_INIT 3'h5
`define SMX_TRIES_ZERO 3'h0
`define SMX_TRIES_STEP 3'h1
`define SMX_NV_BIT 0
`define SMX_LBA_BIT 6
`define SMX_WORD_FIRST_PW 9'h001
`define SMX_WORD_LAST 9'h0FF
`define SMX_WORD_STEP 9'h001
`endif

/* smx_pkg.sv */
// types shared by the set-max command and security block
package smx_pkg;
	typedef enum logic [1:0] {LK_OPEN, LK_UNLOCKED, LK_LOCKED, LK_FROZEN} lock_type;
	typedef enum logic [1:0] {OP_NONE, OP_SETPW, OP_UNLOCK} op_type;
endpackage

/* pw_sector.sv */
// one-sector password payload capture
`timescale 1ns/100ps
`default_nettype none
`include "smx_params.svh"
module pw_sector #(
	parameter int WORDS = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic word_valid,
	input wire logic [15:0] word,
	output logic sec_done,
	output logic [WORDS*16-1:0] pw
);
	if (WORDS < 1 || WORDS > 254) begin : g_chk
		$error("pw_sector: WORDS out of range");
	end
	typedef struct packed {
		logic active;
		logic done;
		logic [8:0] cnt;
		logic [WORDS-1:0][15:0] words;
	} sec_type;
	sec_type q, d;
	always_comb begin
		d = q;
		d.done = 1'b0;
		// the first word may arrive in the very cycle the sector opens
		if (start) begin
			d.active = 1'b1;
			d.cnt = 9'h000;
		end
		if (d.active && word_valid) begin
			// only words 1..WORDS hold the password; the rest are dropped
			for (int i = 0; i < WORDS; i++) begin
				if (d.cnt == 9'(i) + `SMX_WORD_FIRST_PW) begin
					d.words[i] = word;
				end
			end
			if (d.cnt == `SMX_WORD_LAST) begin
				d.active = 1'b0;
				d.done = 1'b1;
			end
			d.cnt = d.cnt + `SMX_WORD_STEP;
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign sec_done = q.done;
	assign pw = q.words;
endmodule
`default_nettype wire

/* smx_cmd.sv */
// set-max address decode and password lock/freeze state machine
// What this block does
// - sector count bit 0 selects kept-over-POR address
// - non-volatile request aborts in offset mode
// - LBA address from sector, cylinders, head nibble
// - CHS takes cylinder only, ignores sector, head
// - LBA completion returns set address, same split
// - CHS completion returns sector 63, cylinder, head
// - feature 01h means set password
// - address setting only right after native read
// - set password takes exactly one sector
// - password is words 1 to 16
// - password lost at power cycle
// - accepted set password leaves device unlocked
// - feature 02h locks the device
// - locked rejects all but unlock and freeze
// - locked until power cycle, unlock or freeze
// - wrong unlock password aborts, counts five tries
// - matching unlock password unlocks the device
// - frozen rejects address, password, lock, unlock
`timescale 1ns/100ps
`default_nettype none
`include "smx_params.svh"
module smx_cmd
	import smx_pkg::*;
#(
	parameter int PW_WORDS = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] feature,
	input wire logic [7:0] sect_cnt,
	input wire logic [7:0] sect_num,
	input wire logic [7:0] cyl_lo,
	input wire logic [7:0] cyl_hi,
	input wire logic [7:0] dev_head,
	input wire logic native_prev,
	input wire logic offset_mode,
	input wire logic [27:0] native_max,
	input wire logic [3:0] max_head,
	input wire logic data_valid,
	input wire logic [15:0] data_word,
	output logic data_req,
	output logic done,
	output logic [7:0] status,
	output logic [7:0] error,
	output logic [7:0] ret_sect_num,
	output logic [7:0] ret_cyl_lo,
	output logic [7:0] ret_cyl_hi,
	output logic [3:0] ret_head,
	output logic [27:0] max_addr,
	output logic max_nv,
	output logic max_set,
	output logic pw_unlocked,
	output logic locked,
	output logic frozen,
	output logic [2:0] tries_left
);
	if (PW_WORDS != 16) begin : g_chk
		$error("smx_cmd: password must be 16 words");
	end
	localparam int PW_BITS = PW_WORDS * 16;
	typedef struct packed {
		lock_type lock;
		op_type op;
		logic [PW_BITS-1:0] pw;
		logic [2:0] tries;
		logic nv_used;
		logic [27:0] max_addr;
		logic max_nv;
		logic max_set;
		logic done;
		logic start;
		logic [7:0] sts;
		logic [7:0] err;
		logic [7:0] r_sn;
		logic [7:0] r_cl;
		logic [7:0] r_ch;
		logic [3:0] r_h;
	} st_type;
	st_type q, d;
	logic sec_done;
	logic [PW_BITS-1:0] pw_got;
	logic acc;
	logic lba;
	logic [27:0] req_addr;

	function automatic logic [7:0] sts_f(input logic ab);
		sts_f = `SMX_STS_RDY | (ab ? `SMX_STS_ERR : 8'h00);
	endfunction

	pw_sector #(.WORDS(PW_WORDS)) i_pw_sector (
		.mclk(mclk),
		.rst(rst),
		.start(q.start),
		.word_valid(data_valid && data_req),
		.word(data_word),
		.sec_done(sec_done),
		.pw(pw_got)
	);

	assign acc = cmd_valid && cmd_code == `SMX_OPCODE && q.op == OP_NONE;
	assign lba = dev_head[`SMX_LBA_BIT];
	assign req_addr = lba ? {dev_head[3:0], cyl_hi, cyl_lo, sect_num} : 28'({cyl_hi, cyl_lo});

	always_comb begin
		logic fin;
		logic ab;
		fin = 1'b0;
		ab = 1'b0;
		d = q;
		d.done = 1'b0;
		d.start = 1'b0;
		d.max_set = 1'b0;
		if (acc && native_prev) begin
			fin = 1'b1;
			if (q.lock == LK_LOCKED || q.lock == LK_FROZEN) begin
				ab = 1'b1;
			end else if (sect_cnt[`SMX_NV_BIT] && (offset_mode || q.nv_used)) begin
				ab = 1'b1;
			end else if (lba && req_addr > native_max) begin
				ab = 1'b1;
			end else begin
				d.max_addr = req_addr;
				d.max_nv = sect_cnt[`SMX_NV_BIT];
				d.nv_used = q.nv_used | sect_cnt[`SMX_NV_BIT];
				d.max_set = 1'b1;
				if (lba) begin
					d.r_sn = req_addr[7:0];
					d.r_cl = req_addr[15:8];
					d.r_ch = req_addr[23:16];
					d.r_h = req_addr[27:24];
				end else begin
					d.r_sn = `SMX_CHS_MAX_SECT;
					d.r_cl = cyl_lo;
					d.r_ch = cyl_hi;
					d.r_h = max_head;
				end
			end
		end else if (acc) begin
			case (feature)
				`SMX_FEAT_SETPW: begin
					if (q.lock == LK_LOCKED || q.lock == LK_FROZEN) begin
						fin = 1'b1;
						ab = 1'b1;
					end else begin
						d.op = OP_SETPW;
						d.start = 1'b1;
					end
				end
				`SMX_FEAT_LOCK: begin
					fin = 1'b1;
					if (q.lock == LK_LOCKED || q.lock == LK_FROZEN) begin
						ab = 1'b1;
					end else begin
						d.lock = LK_LOCKED;
					end
				end
				`SMX_FEAT_UNLOCK: begin
					if (q.lock == LK_FROZEN || q.tries == `SMX_TRIES_ZERO) begin
						fin = 1'b1;
						ab = 1'b1;
					end else begin
						d.op = OP_UNLOCK;
						d.start = 1'b1;
					end
				end
				`SMX_FEAT_FREEZE: begin
					fin = 1'b1;
					d.lock = LK_FROZEN;
				end
				default: begin
					fin = 1'b1;
					ab = 1'b1;
				end
			endcase
		end else if (q.op != OP_NONE && sec_done) begin
			fin = 1'b1;
			d.op = OP_NONE;
			if (q.op == OP_SETPW) begin
				d.pw = pw_got;
				d.lock = LK_UNLOCKED;
			end else if (pw_got == q.pw) begin
				d.lock = LK_UNLOCKED;
			end else begin
				ab = 1'b1;
				d.tries = q.tries - `SMX_TRIES_STEP;
			end
		end
		if (fin) begin
			d.done = 1'b1;
			d.sts = sts_f(ab);
			d.err = ab ? `SMX_ERR_ABT : `SMX_ERR_NONE;
		end else if (d.op != OP_NONE) begin
			d.sts = `SMX_STS_RDY | `SMX_STS_DRQ;
			d.err = `SMX_ERR_NONE;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.sts <= `SMX_STS_RDY;
			q.tries <= `SMX_TRIES_INIT;
		end else begin
			q <= d;
		end
	end

	assign data_req = q.op != OP_NONE;
	assign done = q.done;
	assign status = q.sts;
	assign error = q.err;
	assign ret_sect_num = q.r_sn;
	assign ret_cyl_lo = q.r_cl;
	assign ret_cyl_hi = q.r_ch;
	assign ret_head = q.r_h;
	assign max_addr = q.max_addr;
	assign max_nv = q.max_nv;
	assign max_set = q.max_set;
	assign pw_unlocked = q.lock == LK_UNLOCKED;
	assign locked = q.lock == LK_LOCKED;
	assign frozen = q.lock == LK_FROZEN;
	assign tries_left = q.tries;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_PERSIST: assert property (acc && native_prev |=> error != `SMX_ERR_NONE
		|| max_nv == $past(sect_cnt[`SMX_NV_BIT]))
		else $error("persistence flag not taken from sector count");
	AST_NV_OFFSET: assert property (acc && native_prev && sect_cnt[`SMX_NV_BIT] && offset_mode
		|=> done && error == `SMX_ERR_ABT)
		else $error("non-volatile request accepted in offset mode");
	AST_LBA: assert property (acc && native_prev && lba |=> error != `SMX_ERR_NONE
		|| (max_addr == {$past(dev_head[3:0]), $past(cyl_hi), $past(cyl_lo), $past(sect_num)}
		&& ret_sect_num == $past(sect_num) && ret_head == $past(dev_head[3:0])))
		else $error("lba address not assembled or returned");
	AST_CHS: assert property (acc && native_prev && !lba |=> error != `SMX_ERR_NONE
		|| (ret_sect_num == `SMX_CHS_MAX_SECT && ret_head == $past(max_head) && ret_cyl_hi == $past(cyl_hi)))
		else $error("chs return values wrong");
	AST_LOCKED_REJECT: assert property (acc && locked && (native_prev || feature == `SMX_FEAT_SETPW
		|| feature == `SMX_FEAT_LOCK) |=> done && error == `SMX_ERR_ABT && locked)
		else $error("locked device accepted a request");
	AST_FROZEN: assert property (acc && frozen && (native_prev || feature != `SMX_FEAT_FREEZE)
		|=> done && error == `SMX_ERR_ABT && frozen)
		else $error("frozen device accepted a request");
	AST_LOCK: assert property (acc && !native_prev && feature == `SMX_FEAT_LOCK && !locked && !frozen
		|=> locked && done && error == `SMX_ERR_NONE)
		else $error("lock request did not lock");
	AST_SETPW_DRQ: assert property (acc && !native_prev && feature == `SMX_FEAT_SETPW && !locked && !frozen
		|=> data_req && !done)
		else $error("set password did not open data phase");
	AST_SETPW_DONE: assert property (q.op == OP_SETPW && sec_done |=> pw_unlocked && done && !data_req)
		else $error("set password did not unlock");
	AST_TRIES: assert property (q.op == OP_UNLOCK && sec_done && pw_got != q.pw
		|=> tries_left == 3'($past(tries_left) - `SMX_TRIES_STEP) && error == `SMX_ERR_ABT)
		else $error("failed unlock did not count down");
	AST_ABORT_STS: assert property (done && error != `SMX_ERR_NONE |-> status == (`SMX_STS_RDY | `SMX_STS_ERR))
		else $error("abort status wrong");
	CV_UNLOCK: cover property (locked ##[1:600] pw_unlocked);
	CV_FREEZE: cover property (acc && feature == `SMX_FEAT_FREEZE ##1 frozen);
	CV_TRIES_OUT: cover property (tries_left == `SMX_TRIES_ZERO);
	CV_SET_ADDR: cover property (max_set);
endmodule
`default_nettype wire

/* host_sector.sv */
// host model feeding the one-sector password payload
`timescale 1ns/100ps
`default_nettype none
module host_sector (
	input wire logic mclk,
	input wire logic data_req,
	input wire logic slow,
	input wire logic [255:0] pw,
	output logic data_valid,
	output logic [15:0] data_word
);
	int idx = 0;
	initial begin
		data_valid = 1'b0;
		data_word = 16'h0000;
	end
	always @(negedge mclk) begin
		if (data_req && idx < 256 && !(slow && idx[0] && data_valid)) begin
			data_valid <= 1'b1;
			data_word <= (idx >= 1 && idx <= 16) ? pw[16*(idx-1)+:16] : 16'(idx * 40503);
			idx <= idx + 1;
		end else begin
			data_valid <= 1'b0;
			data_word <= ~data_word;
			if (!data_req) idx <= 0;
		end
	end
endmodule
`default_nettype wire

/* max_address_security_commands_tb.sv */
// self-checking bench for the set-max command and security block
`timescale 1ns/100ps
`default_nettype none
module max_address_security_commands_tb;
	logic mclk, rst, cmd_valid, native_prev, offset_mode, data_valid, data_req, done, max_nv, max_set, slow;
	logic pw_unlocked, locked, frozen, e_nv;
	logic [7:0] cmd_code, feature, sect_cnt, sect_num, cyl_lo, cyl_hi, dev_head, status, error;
	logic [7:0] ret_sect_num, ret_cyl_lo, ret_cyl_hi, e_sn, e_cl, e_ch;
	logic [27:0] native_max, max_addr, e_addr;
	logic [3:0] max_head, ret_head, e_hd;
	logic [15:0] data_word;
	logic [2:0] tries_left;
	logic [255:0] pw_host, pw_dev;
	logic [31:0] rnd;
	int fails = 0;
	int checked = 0;
	int lk, tr, nvu;
	smx_cmd i_smx_cmd (.mclk, .rst, .cmd_valid, .cmd_code, .feature, .sect_cnt, .sect_num, .cyl_lo, .cyl_hi,
		.dev_head, .native_prev, .offset_mode, .native_max, .max_head, .data_valid, .data_word, .data_req, .done,
		.status, .error, .ret_sect_num, .ret_cyl_lo, .ret_cyl_hi, .ret_head, .max_addr, .max_nv, .max_set,
		.pw_unlocked, .locked, .frozen, .tries_left);
	host_sector i_host_sector (.mclk, .data_req, .slow, .pw(pw_host), .data_valid, .data_word);
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		{lk, nvu, pw_dev, e_nv, e_addr, e_sn, e_cl, e_ch, e_hd} = '0;
		tr = 5;
		chk({status, error, data_req, tries_left}, {8'h40, 8'h00, 1'b0, 3'h5});
		chk({pw_unlocked, locked, frozen}, 3'b000);
	endtask
	// one command through the design and through the reference model
	task automatic run(input logic [7:0] f, input logic prev, input logic [7:0] sc, sn, cl, ch, dh);
		logic ok;
		logic [27:0] a;
		int n;
		a = dh[6] ? {dh[3:0], ch, cl, sn} : {12'h000, ch, cl};
		if (prev) ok = lk < 2 && !(sc[0] && (offset_mode || nvu != 0)) && !(dh[6] && a > native_max);
		else case (f)
			8'h01, 8'h02: ok = lk < 2;
			8'h03: ok = lk != 3 && tr != 0 && pw_host === pw_dev;
			8'h04: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		{feature, native_prev, sect_cnt, sect_num, cyl_lo, cyl_hi, dev_head} = {f, prev, sc, sn, cl, ch, dh};
		cmd_valid = 1'b1;
		@(negedge mclk);
		cmd_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 600) begin
			if (data_req === 1'b1 && n == 1) chk(status, 8'h48);
			@(negedge mclk);
			n++;
		end
		if (f == 8'h03 && !prev && !ok && lk != 3 && tr != 0) tr--;
		if (ok && prev) begin
			{e_nv, e_addr, e_sn, e_cl, e_ch} = {sc[0], a, dh[6] ? sn : 8'h3F, cl, ch};
			e_hd = dh[6] ? dh[3:0] : max_head;
			nvu = nvu | int'(sc[0]);
		end
		if (ok && !prev) lk = f == 8'h04 ? 3 : f == 8'h02 ? 2 : 1;
		if (ok && f == 8'h01 && !prev) pw_dev = pw_host;
		chk({done, max_set}, {1'b1, ok && prev});
		chk({status, error}, ok ? 16'h4000 : 16'h4104);
		chk({pw_unlocked, locked, frozen}, {lk == 1, lk == 2, lk == 3});
		chk(tries_left, tr);
		chk({max_nv, max_addr}, {e_nv, e_addr});
		chk({ret_sect_num, ret_cyl_lo, ret_cyl_hi, ret_head}, {e_sn, e_cl, e_ch, e_hd});
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		#500000;
		fails++;
		report_and_stop();
	end
	initial begin
		{rst, cmd_valid, native_prev, offset_mode, slow, feature, sect_cnt, sect_num, cyl_lo, cyl_hi} = '0;
		{dev_head, max_head, pw_host} = '0;
		cmd_code = 8'hF9;
		native_max = 28'h0FFFFFF;
		rnd = 32'h0D3A;
		do_reset();
		offset_mode = 1'b1;
		run(8'h00, 1'b1, 8'h01, 8'h12, 8'h34, 8'h56, 8'hE0);
		offset_mode = 1'b0;
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			max_head = rnd[31:28];
			run(8'h00, 1'b1, {7'h00, i[2]}, rnd[7:0], rnd[15:8], rnd[23:16], {1'b1, i[0], 2'b10, rnd[27:24]});
		end
		cmd_code = 8'hEF;
		cmd_valid = 1'b1;
		@(negedge mclk);
		cmd_valid = 1'b0;
		cmd_code = 8'hF9;
		repeat (3) begin
			chk(done, 1'b0);
			@(negedge mclk);
		end
		$display("test address forms done");
		pw_host = {8{rnd}};
		slow = 1'b1;
		run(8'h01, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0);
		slow = 1'b0;
		for (int k = 0; k < 3; k++) run(k == 0 ? 8'h02 : 8'(k - 1), k == 1, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0);
		run(8'h02, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0);
		pw_host = ~pw_host;
		run(8'h03, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0);
		pw_host = ~pw_host;
		run(8'h03, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0);
		run(8'h05, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0);
		run(8'h02, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0);
		run(8'h04, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0);
		for (int k = 0; k < 4; k++) run(8'(k), k == 0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0);
		$display("test lock and freeze done");
		do_reset();
		run(8'h01, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0);
		pw_host = ~pw_host;
		for (int k = 0; k < 6; k++) run(8'h03, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0);
		pw_host = ~pw_host;
		run(8'h03, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0);
		$display("test unlock attempts done");
		report_and_stop();
	end
endmodule
`default_nettype wire
